// [regsel_defines.svh]
// register map, field positions and reset values of the regulator control block
`ifndef REGSEL_DEFINES_SVH
`define REGSEL_DEFINES_SVH

// byte offsets
`define OFS_DEV_CTRL2      8'h00
`define OFS_EN_ASSIGN      8'h04
`define OFS_KEEP_ON        8'h08
`define OFS_SET_OFF        8'h0C
`define OFS_ACT_CHOICE     8'h10
`define OFS_SLP_CHOICE     8'h14
`define OFS_SEL_MAP        8'h18
`define OFS_STATUS         8'h1C
`define OFS_VOLT_BASE      8'h20
`define OFS_VOLT_LAST      8'h3C

// device control two fields
`define BIT_SLEEP_ARM      0
`define BIT_SLEEP_PIN_POLARITY_BIT      1

// voltage register fields
`define VOLT_PRIM_LSB      0
`define VOLT_ALT_LSB       8

// status fields
`define STAT_STATE_LSB     0
`define STAT_ON_LSB        8
`define STAT_LP_LSB        16
`define STAT_ALT_LSB       24

// reset values, then the AHB transfer-type bit and word size code
`define RST_DEV_CTRL2      2'h0
`define RST_KEEP_ON        8'h00
`define RST_SET_OFF        8'h00
`define RST_ACT_CHOICE     8'h00
`define RST_SLP_CHOICE     8'h00
`define RST_SEL_MAP        8'hE4
`define RST_VOLT           16'h0000
`define HTRANS_NONSEQ_BIT  1
`define HSIZE_WORD         3'h2

`endif

// [regsel_pkg.sv]
// types shared by the regulator control block
package regsel_pkg;
  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_active = 2'b01,
    st_sleep  = 2'b10
  } dev_state_t;
endpackage

// [regulator_state_voltage_select.sv]
// regulator mode and voltage-register selection with AHB-Lite register access
`include "regsel_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - each resource holds primary and alternate voltage
// - strap low: select pin picks register
// - strap high, awake: active choice picks
// - strap high, asleep: active or sleep choice
// - assigned resource ORs pins, else device state
// - regulators one-four map select pin by register
// - many resources per pin, many pins each
// - assignments load defaults, software may rewrite
// - enable pins act only in ACTIVE, SLEEP
// - sleep pin moves device into SLEEP
// - sleep pin needs arm bit, no interrupts
// - polarity bit sets sleep pin level
// - unassigned sleeping, keep-on keeps it enabled
// - unassigned sleeping, both zero: low power
// - unassigned sleeping, off only: turned off
// - assigned resource follows pin, ignores sleep
// - assigned pin high: always enabled
// - assigned pin low: keep, off, low power
// - strap low: enable pins only select voltage
// - strap low: request pins use sets one-three
module regulator_state_voltage_select
  import regsel_pkg::*;
#(
  parameter int          NRES          = 8,            // 4 converters then 4 regulators
  parameter int          NPIN          = 4,            // enable pins
  parameter int          VW            = 8,            // voltage code width
  parameter logic [31:0] OTP_EN_ASSIGN = 32'h0000_0000 // power-up assignment image
) (
  input  wire logic              mclk,          // 250 MHz clock
  input  wire logic              rst_b,         // synchronous reset, active low
  input  wire logic              hsel,          // AHB slave select
  input  wire logic [7:0]        haddr,         // AHB byte address
  input  wire logic [1:0]        htrans,        // AHB transfer type
  input  wire logic              hwrite,        // AHB write
  input  wire logic [2:0]        hsize,         // AHB size, word only
  input  wire logic [31:0]       hwdata,        // AHB write data
  input  wire logic              hready,        // AHB bus ready
  output logic                   hreadyout,     // AHB slave ready
  output logic                   hresp,         // AHB response, always OKAY
  output logic [31:0]            hrdata,        // AHB read data
  input  wire logic              pin_remap_strap,       // remap strap pin
  input  wire logic [NPIN-1:0]   resource_enable_pin,   // enable or select pins
  input  wire logic              sleep_pin,             // sleep request pin
  input  wire logic              power_request_pin,     // strap-low enable pin
  input  wire logic              clock_request_pin_one, // strap-low enable pin
  input  wire logic              clock_request_pin_two, // strap-low enable pin
  input  wire logic              power_up_done,  // sequencer reached run states
  input  wire logic              irq_pending,    // some unmasked interrupt set
  output logic [1:0]             dev_state,      // device state code
  output logic [NRES-1:0]        res_enable,     // resource enabled
  output logic [NRES-1:0]        res_low_power,  // resource in low-power mode
  output logic [NRES-1:0]        res_use_alt,    // alternate register in use
  output logic [NRES*VW-1:0]     res_voltage     // selected voltage codes
);

  localparam int NCNV = 4;
  localparam int NSYN = NPIN + 5;

  initial begin
    if (NRES != 8 || NPIN != 4 || VW < 1 || VW > 8) begin
      $error("regulator_state_voltage_select: unsupported parameters");
    end
  end

  function automatic logic [NPIN-1:0] assign_col(input logic [31:0] a, input int r);
    logic [NPIN-1:0] c;
    c = '0;
    for (int p = 0; p < NPIN; p++) begin
      c[p] = a[p*NRES + r];
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [NSYN-1:0] sync1_q;
  logic [NSYN-1:0] sync2_q;
  wire  [NSYN-1:0] pins_raw = {pin_remap_strap, sleep_pin, clock_request_pin_two,
                               clock_request_pin_one, power_request_pin,
                               resource_enable_pin};

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire [NPIN-1:0] en_s     = sync2_q[NPIN-1:0];
  wire            pwr_s    = sync2_q[NPIN];
  wire            clk1_s   = sync2_q[NPIN+1];
  wire            clk2_s   = sync2_q[NPIN+2];
  wire            sleep_s  = sync2_q[NPIN+3];
  wire            strap_s  = sync2_q[NPIN+4];

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [1:0]        ctrl_q;
  logic [31:0]       assign_q;
  logic [NRES-1:0]   keep_q;
  logic [NRES-1:0]   off_q;
  logic [NRES-1:0]   act_q;
  logic [NRES-1:0]   slp_q;
  logic [7:0]        map_q;
  logic [15:0]       volt_q [NRES];
  dev_state_t        state_q;
  dev_state_t        state_d;

  ////////////////////////////////////////////////////////////////////////////////
  // register bus

  // AHB address phase capture; sub-word transfers are not taken
  wire        ap_take = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready & (hsize == `HSIZE_WORD);
  logic       wr_q;
  logic       rd_q;
  logic [7:0] addr_q;
  logic       rd_wait_q;

  // reads take one wait state so a write just before always shows
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      addr_q    <= 8'h00;
      rd_wait_q <= 1'b0;
    end else begin
      if (hreadyout) begin
        wr_q   <= ap_take & hwrite;
        rd_q   <= ap_take & ~hwrite;
        addr_q <= haddr;
      end
      rd_wait_q <= hreadyout & ap_take & ~hwrite;
    end
  end

  assign hreadyout = ~rd_wait_q;
  assign hresp     = 1'b0;

  wire       in_volt  = (addr_q >= `OFS_VOLT_BASE) && (addr_q <= `OFS_VOLT_LAST);
  wire [2:0] volt_idx = addr_q[4:2];
  wire       wr_ctrl  = wr_q && addr_q == `OFS_DEV_CTRL2;
  wire       wr_asg   = wr_q && addr_q == `OFS_EN_ASSIGN;
  wire       wr_keep  = wr_q && addr_q == `OFS_KEEP_ON;
  wire       wr_off   = wr_q && addr_q == `OFS_SET_OFF;
  wire       wr_act   = wr_q && addr_q == `OFS_ACT_CHOICE;
  wire       wr_slp   = wr_q && addr_q == `OFS_SLP_CHOICE;
  wire       wr_map   = wr_q && addr_q == `OFS_SEL_MAP;
  wire       wr_volt  = wr_q && in_volt;

  ////////////////////////////////////////////////////////////////////////////////
  // register file

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_q <= `RST_DEV_CTRL2;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      assign_q <= OTP_EN_ASSIGN;
    end else if (wr_asg) begin
      assign_q <= hwdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      keep_q <= `RST_KEEP_ON;
    end else if (wr_keep) begin
      keep_q <= hwdata[NRES-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      off_q <= `RST_SET_OFF;
    end else if (wr_off) begin
      off_q <= hwdata[NRES-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      act_q <= `RST_ACT_CHOICE;
    end else if (wr_act) begin
      act_q <= hwdata[NRES-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      slp_q <= `RST_SLP_CHOICE;
    end else if (wr_slp) begin
      slp_q <= hwdata[NRES-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      map_q <= `RST_SEL_MAP;
    end else if (wr_map) begin
      map_q <= hwdata[7:0];
    end
  end

  // primary and alternate settings per resource
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int r = 0; r < NRES; r++) begin
        volt_q[r] <= `RST_VOLT;
      end
    end else if (wr_volt) begin
      volt_q[volt_idx] <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  wire [31:0] status_w = {res_use_alt, res_low_power, res_enable, 6'h00, dev_state};

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_q)
      `OFS_DEV_CTRL2:  rd_mux = {30'h0000_0000, ctrl_q};
      `OFS_EN_ASSIGN:  rd_mux = assign_q;
      `OFS_KEEP_ON:    rd_mux = {24'h00_0000, keep_q};
      `OFS_SET_OFF:    rd_mux = {24'h00_0000, off_q};
      `OFS_ACT_CHOICE: rd_mux = {24'h00_0000, act_q};
      `OFS_SLP_CHOICE: rd_mux = {24'h00_0000, slp_q};
      `OFS_SEL_MAP:    rd_mux = {24'h00_0000, map_q};
      `OFS_STATUS:     rd_mux = status_w;
      default: begin
        if (in_volt) rd_mux = {16'h0000, volt_q[volt_idx]};
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_q && rd_wait_q) begin
      hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // device state

  wire sleep_arm = ctrl_q[`BIT_SLEEP_ARM];
  wire sleep_pin_polarity_bit = ctrl_q[`BIT_SLEEP_PIN_POLARITY_BIT];
  // strap low masks the sleep pin, so the device never enters SLEEP
  wire sleep_lvl = strap_s & (sleep_s == sleep_pin_polarity_bit);
  wire sleep_req = sleep_lvl & sleep_arm & ~irq_pending;

  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle:   if (power_up_done) state_d = st_active;
      st_active: begin
        if (!power_up_done) state_d = st_idle;
        else if (sleep_req) state_d = st_sleep;
      end
      st_sleep: begin
        if (!power_up_done) state_d = st_idle;
        else if (!sleep_req) state_d = st_active;
      end
      default:   state_d = st_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) state_q <= st_idle;
    else state_q <= state_d;
  end

  assign dev_state = state_q;

  wire run      = (state_q == st_active) || (state_q == st_sleep);
  wire awake    = (state_q == st_active);
  // strap low: request pins replace enable pins, fourth set's pin held low
  wire [NPIN-1:0] en_pins = strap_s ? en_s : {1'b0, clk2_s, clk1_s, pwr_s};

  ////////////////////////////////////////////////////////////////////////////////
  // per-resource mode and voltage choice

  logic [NRES-1:0] en_d;
  logic [NRES-1:0] lp_d;
  logic [NRES-1:0] alt_d;
  wire  [NRES*VW-1:0] volt_d;

  for (genvar r = 0; r < NRES; r++) begin : g_res
    wire [NPIN-1:0] col      = assign_col(assign_q, r);
    wire            assigned = run & (|col);
    wire            pin_or   = |(col & en_pins);
    // high means behave as ACTIVE
    wire            high     = assigned ? pin_or : (awake | ~strap_s);
    wire [1:0]      map_f    = (r >= NCNV) ? map_q[2*(r%NCNV) +: 2] : 2'(r);
    wire            sel_pin  = en_s[map_f];
    wire            choice   = ~strap_s ? sel_pin :
                               high ? act_q[r] :
                               (act_q[r] | slp_q[r]);
    assign en_d[r]  = run & (high | keep_q[r] | ~off_q[r]);
    assign lp_d[r]  = run & ~high & ~keep_q[r] & ~off_q[r];
    assign alt_d[r] = choice;
    // code follows the same-cycle choice so code and flag move together
    assign volt_d[r*VW +: VW] = alt_d[r] ? volt_q[r][`VOLT_ALT_LSB +: VW] :
                                           volt_q[r][`VOLT_PRIM_LSB +: VW];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      res_enable    <= '0;
      res_low_power <= '0;
      res_use_alt   <= '0;
    end else begin
      res_enable    <= en_d;
      res_low_power <= lp_d;
      res_use_alt   <= alt_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) res_voltage <= '0;
    else res_voltage <= volt_d;
  end

endmodule

// [rsvs_asserts.sv]
// bus handshake and mode-decision checks for the regulator control block
module rsvs_checker #(
  parameter int NRES = 8 // resources
) (
  input wire logic            mclk,            // clock
  input wire logic            rst_b,           // sync reset
  input wire logic            hsel,            // select
  input wire logic [1:0]      htrans,          // transfer type
  input wire logic            hwrite,          // write
  input wire logic            hready,          // bus ready
  input wire logic            hreadyout,       // slave ready
  input wire logic            hresp,           // response
  input wire logic            pin_remap_strap, // strap
  input wire logic            power_up_done,   // run allowed
  input wire logic            irq_pending,     // interrupt
  input wire logic [1:0]      dev_state,       // state
  input wire logic [NRES-1:0] res_enable,      // enabled
  input wire logic [NRES-1:0] res_low_power    // low power
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire req = hsel && htrans[1] && hready;
  chk_read_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  chk_write_nowait: assert property (req && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_idle_off: assert property ((dev_state == 2'h0)[*2] |-> (res_enable | res_low_power) == '0)
    else $error("resource active while idle");
  chk_pud_idle: assert property (!power_up_done |=> dev_state == 2'h0)
    else $error("state not idle without power up");
  chk_irq_hold: assert property (irq_pending && dev_state != 2'h2 |=> dev_state != 2'h2)
    else $error("sleep entered with interrupt pending");
  chk_strap_nosleep: assert property (!pin_remap_strap[*5] |-> dev_state != 2'h2)
    else $error("sleep with strap low");
  chk_lp_enabled: assert property ((res_low_power & ~res_enable) == '0)
    else $error("low power on a disabled resource");
endmodule
bind regulator_state_voltage_select rsvs_checker #(.NRES(NRES)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .pin_remap_strap(pin_remap_strap),
  .power_up_done(power_up_done), .irq_pending(irq_pending), .dev_state(dev_state),
  .res_enable(res_enable), .res_low_power(res_low_power));

// [host_pins.sv]
// host-side pin driver: enable, sleep and request pins, prompt or late
module host_pins (
  input  wire logic [1:0] lag,  // edges of delay
  input  wire logic       mclk, // clock
  input  wire logic [7:0] want, // {req2,req1,preq,sleep,en[3:0]}
  output logic      [7:0] pins  // pin levels seen by the device
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pipe_q [3];
  always @(posedge mclk) begin
    pipe_q[0] <= want;
    pipe_q[1] <= pipe_q[0];
    pipe_q[2] <= pipe_q[1];
  end
  // a slow host shows the level some edges late
  assign pins = (lag == 2'h0) ? want : pipe_q[lag - 2'h1];
endmodule

// [tb_regulator_state_voltage_select.sv]
// self-checking bench for the regulator mode and voltage selection block
module tb_regulator_state_voltage_select;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] OTP = 32'h0300_0C81;
  logic        mclk = 0, rst_b = 0, hsel = 0, hwrite = 0, strap = 1, pud = 0, irq = 0;
  logic [1:0]  htrans = 0, lag = 0, ctrl, est, dev_state;
  logic [7:0]  haddr = 0, want = 0, pins, en, lp, alt, keep, off, act, slp, selmap;
  logic [31:0] hwdata = 0, hrdata, rd, asg;
  logic [63:0] volt;
  logic [23:0] e;
  logic [15:0] vreg [8];
  logic        hreadyout, hresp;
  int          error_cnt = 0, comparisons = 0, seed = 37947, cycles = 0;

  regulator_state_voltage_select #(.OTP_EN_ASSIGN(OTP)) DUT (
    .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pin_remap_strap(strap), .resource_enable_pin(pins[3:0]),
    .sleep_pin(pins[4]), .power_request_pin(pins[5]), .clock_request_pin_one(pins[6]),
    .clock_request_pin_two(pins[7]), .power_up_done(pud), .irq_pending(irq),
    .dev_state(dev_state), .res_enable(en), .res_low_power(lp), .res_use_alt(alt),
    .res_voltage(volt));
  host_pins partner (.lag(lag), .mclk(mclk), .want(want), .pins(pins));

  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 6000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // ready and read data are taken at the rising edge, as the slave's flops see them
  task automatic wait_rdy();
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  // steady-state {use_alt, low_power, enable} for the programmed setup
  function automatic logic [23:0] expect_out(input logic [1:0] st);
    logic [23:0] x;
    logic [3:0]  p, c;
    logic        h, s;
    x = '0;
    p = strap ? want[3:0] : {1'b0, want[7:5]};
    for (int r = 0; r < 8; r++) begin
      c = {asg[24+r], asg[16+r], asg[8+r], asg[r]};
      h = (|c) ? |(p & c) : (st == 2'h1 || !strap);
      s = (r < 4) ? want[r] : want[selmap[2*(r-4) +: 2]];
      x[r] = pud & (h | keep[r] | ~off[r]);
      x[8+r] = pud & ~h & ~keep[r] & ~off[r];
      x[16+r] = strap ? (act[r] | (~h & slp[r])) : s;
    end
    return x;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 8'h04, 0);
    check("assign reset", rd, OTP);
    bus(1'b0, 8'h18, 0);
    check("select map reset", rd, 32'h0000_00E4);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 0);
    check("unmapped", rd, 0);
    for (int r = 0; r < 8; r++) begin
      vreg[r] = 16'($random(seed));
      bus(1'b1, 8'(8'h20 + 4 * r), {16'h0000, vreg[r]});
    end
    for (int i = 0; i < 60; i++) begin
      strap <= (i % 4 != 3);
      pud   <= (i % 7 != 6);
      irq   <= (i % 5 == 4);
      lag   <= 2'($random(seed));
      want  <= (i < 8) ? 8'h10 : 8'($random(seed));
      {keep, off, act, slp, selmap} = 40'({$random(seed), $random(seed)});
      asg = $random(seed);
      ctrl = 2'($random(seed));
      // corner: armed sleep, nothing assigned, every keep/off pair
      if (i < 8) begin
        asg = 0;
        ctrl = 2'h3;
        keep = 8'hF0;
        off = 8'hCC;
      end
      if (i % 4 == 3) asg[31:24] = 8'h00;
      bus(1'b1, 8'h00, {30'h0, ctrl});
      bus(1'b1, 8'h04, asg);
      bus(1'b1, 8'h08, {24'h0, keep});
      bus(1'b1, 8'h0C, {24'h0, off});
      bus(1'b1, 8'h10, {24'h0, act});
      bus(1'b1, 8'h14, {24'h0, slp});
      bus(1'b1, 8'h18, {24'h0, selmap});
      bus(1'b0, 8'h04, 0);
      check("assign", rd, asg);
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      est = !pud ? 2'h0 : (strap & ctrl[0] & !irq & (want[4] == ctrl[1])) ? 2'h2 : 2'h1;
      e = expect_out(est);
      check("state", dev_state, est);
      check("mode", {lp, en}, e[15:0]);
      if (pud) begin
        check("alt", alt, e[23:16]);
        for (int r = 0; r < 8; r++)
          check("volt", volt[8*r +: 8], e[16+r] ? vreg[r][15:8] : vreg[r][7:0]);
      end
      @(posedge mclk);
      bus(1'b0, 8'h1C, 0);
      check("status", rd[23:0], {e[15:0], 6'h00, est});
      if (pud) check("status alt", rd[31:24], e[23:16]);
    end
    report_and_stop();
  end
endmodule
